// ===== rtl/ttpu_top.sv
// Purpose: Three software timers with PWM outputs behind an APB slave
// Assumes: sys_tick (16 MHz), slow_tick (32 kHz) and sleep_tick are pclk pulses
// Notes:   Zero wait states; unmapped addresses answer with pslverr
`include "ttpu_map.svh"
module ttpu_top
  import ttpu_pkg::*;
#(
  parameter int T0_W = 16,
  parameter int T2_W = 14
) (
  // Clock, reset, clock enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Tick sources
  input  wire logic        sys_tick,
  input  wire logic        slow_tick,
  input  wire logic        sleep_tick,
  input  wire logic        sleep_active,
  input  wire logic        radio_active,
  // Capture pins
  input  wire logic [1:0]  capture_pin,
  // Outputs
  output logic             primary_pulse_out,
  output logic             inverted_pulse_out,
  output logic             shot_pulse_out,
  output logic             sleep_pulse_out,
  output logic [2:0]       triple_pulse_out,
  output logic             first_timer_irq,
  output logic             second_timer_irq,
  output logic             triple_timer_irq
);
  if (T0_W != 16 || T2_W < 2 || T2_W > 16) begin : g_chk
    $error("ttpu_top: unsupported counter width");
  end

  ttpu_t0_ctrl_s   t0c_ff;
  ttpu_t1_ctrl_s   t1c_ff;
  ttpu_t2_ctrl_s   t2c_ff;
  logic [15:0]     high_phase_reload_ff, low_phase_reload_ff, period_reload_ff;
  logic [15:0]     main_down_counter_ff, period_cnt_ff, hi_sh_ff, lo_sh_ff;
  logic            phase_hi_ff, half_clk_ff, first_timer_hold_ff;
  logic [15:0]     second_timer_reload_ff, second_timer_count_ff;
  logic [15:0]     capture_first_value_ff, capture_second_value_ff;
  logic [15:0]     pulse_width_value_ff, sleep_pwm_period_ff, sleep_pwm_duty_ff;
  logic [15:0]     shot_cnt_ff, spwm_cnt_ff;
  ttpu_shot_e      shot_st_ff;
  logic [T2_W-1:0] triple_period_value_ff, triple_period_counter_ff;
  logic [T2_W-1:0] triple_duty_counter_ff;
  logic [T2_W-1:0] duty_ff [3], start_ff [3], end_ff [3];
  logic [2:0]      tpwm_ff;
  logic [1:0]      cap_s1_ff, cap_s2_ff, cap_d_ff;
  logic [31:0]     nxt_rdata;
  logic            nxt_err;

  function automatic logic in_triple(input logic [11:0] a, input logic [11:0] base);
    return (a >= base) && (a < base + 12'h00c) && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [1:0] triple_idx(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] d;
    d = a - base;
    return d[3:2];
  endfunction

  // APB decode: data fetched in setup so the access phase answers at once
  wire setup = psel && !penable;
  wire wr    = psel && penable && pwrite && !pslverr;
  assign pready = 1'b1;

  always_comb begin
    nxt_rdata = `TTPU_ERR_RDATA;
    nxt_err   = 1'b0;
    case (paddr)
      `TTPU_T0_CTRL:     nxt_rdata = {25'h0, t0c_ff};
      `TTPU_T0_HIGH,
      `TTPU_T0_LOW:      nxt_rdata = {16'h0, main_down_counter_ff};
      `TTPU_T0_PERIOD:   nxt_rdata = {16'h0, period_cnt_ff};
      `TTPU_HOLD_SET:    nxt_rdata = {31'h0, first_timer_hold_ff};
      `TTPU_HOLD_CLR:    nxt_rdata = `TTPU_ERR_RDATA;
      `TTPU_T1_CTRL:     nxt_rdata = {25'h0, t1c_ff};
      `TTPU_T1_RELOAD:   nxt_rdata = {16'h0, second_timer_reload_ff};
      `TTPU_T1_COUNT:    nxt_rdata = {16'h0, second_timer_count_ff};
      `TTPU_T1_CAP1:     nxt_rdata = {16'h0, capture_first_value_ff};
      `TTPU_T1_CAP2:     nxt_rdata = {16'h0, capture_second_value_ff};
      `TTPU_T1_WIDTH:    nxt_rdata = {16'h0, pulse_width_value_ff};
      `TTPU_T1_PWM_PER:  nxt_rdata = {16'h0, sleep_pwm_period_ff};
      `TTPU_T1_PWM_DUTY: nxt_rdata = {16'h0, sleep_pwm_duty_ff};
      `TTPU_T2_CTRL:     nxt_rdata = {30'h0, t2c_ff};
      `TTPU_T2_PERIOD:   nxt_rdata = 32'(triple_period_value_ff);
      default: begin
        if (in_triple(paddr, `TTPU_T2_DUTY0)) begin
          nxt_rdata = 32'(duty_ff[triple_idx(paddr, `TTPU_T2_DUTY0)]);
        end else if (in_triple(paddr, `TTPU_T2_START0)) begin
          nxt_rdata = 32'(start_ff[triple_idx(paddr, `TTPU_T2_START0)]);
        end else if (in_triple(paddr, `TTPU_T2_END0)) begin
          nxt_rdata = 32'(end_ff[triple_idx(paddr, `TTPU_T2_END0)]);
        end else begin
          nxt_err = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= `TTPU_ERR_RDATA;
      pslverr <= 1'b0;
    end else if (ce && setup) begin
      prdata  <= pwrite ? `TTPU_ERR_RDATA : nxt_rdata;
      pslverr <= nxt_err;
    end
  end

  // Register writes; accepted at any time, first timer reloads reach its counters only at the next wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0c_ff                 <= '0;
      t1c_ff                 <= '0;
      t2c_ff                 <= '0;
      high_phase_reload_ff   <= `TTPU_RST_VAL;
      low_phase_reload_ff    <= `TTPU_RST_VAL;
      period_reload_ff       <= `TTPU_RST_VAL;
      second_timer_reload_ff <= `TTPU_RST_VAL;
      pulse_width_value_ff   <= `TTPU_RST_VAL;
      sleep_pwm_period_ff    <= `TTPU_RST_VAL;
      sleep_pwm_duty_ff      <= `TTPU_RST_VAL;
      triple_period_value_ff <= '0;
      for (int i = 0; i < 3; i++) begin
        duty_ff[i]  <= '0;
        start_ff[i] <= '0;
        end_ff[i]   <= '0;
      end
    end else if (ce && wr) begin
      case (paddr)
        `TTPU_T0_CTRL:     t0c_ff <= pwdata[6:0];
        `TTPU_T0_HIGH:     high_phase_reload_ff <= pwdata[15:0];
        `TTPU_T0_LOW:      low_phase_reload_ff <= pwdata[15:0];
        `TTPU_T0_PERIOD:   period_reload_ff <= pwdata[15:0];
        `TTPU_T1_CTRL:     t1c_ff <= pwdata[6:0];
        `TTPU_T1_RELOAD:   second_timer_reload_ff <= pwdata[15:0];
        `TTPU_T1_WIDTH:    pulse_width_value_ff <= pwdata[15:0];
        `TTPU_T1_PWM_PER:  sleep_pwm_period_ff <= pwdata[15:0];
        `TTPU_T1_PWM_DUTY: sleep_pwm_duty_ff <= pwdata[15:0];
        `TTPU_T2_CTRL:     t2c_ff <= pwdata[1:0];
        `TTPU_T2_PERIOD:   triple_period_value_ff <= pwdata[T2_W-1:0];
        default: begin
          if (in_triple(paddr, `TTPU_T2_DUTY0)) begin
            duty_ff[triple_idx(paddr, `TTPU_T2_DUTY0)] <= pwdata[T2_W-1:0];
          end else if (in_triple(paddr, `TTPU_T2_START0)) begin
            start_ff[triple_idx(paddr, `TTPU_T2_START0)] <= pwdata[T2_W-1:0];
          end else if (in_triple(paddr, `TTPU_T2_END0)) begin
            end_ff[triple_idx(paddr, `TTPU_T2_END0)] <= pwdata[T2_W-1:0];
          end
        end
      endcase
    end
  end

  // Hold flag: separate set and clear addresses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_timer_hold_ff <= 1'b0;
    end else if (ce && wr && pwdata[0]) begin
      if (paddr == `TTPU_HOLD_SET) begin
        first_timer_hold_ff <= 1'b1;
      end else if (paddr == `TTPU_HOLD_CLR) begin
        first_timer_hold_ff <= 1'b0;
      end
    end
  end

  // First timer clocking
  logic fast_tick, per_tick;
  wire  run     = t0c_ff.first_timer_run;
  wire  t0_tick = t0c_ff.fast_clock_select ? (t0c_ff.fast_clock_gate && fast_tick)
                                           : slow_tick;
  wire  t0_adv  = run && t0_tick && !first_timer_hold_ff;

  ttpu_tick_div #(.W(3)) u_fast_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .clr      (1'b0),
    .tick_in  (sys_tick),
    .div      (3'((4'h1 << t0c_ff.fast_clock_divider) - 4'h1)),
    .tick_out (fast_tick)
  );

  ttpu_tick_div #(.W(4)) u_per_div (
    .pclk     (pclk),
    .presetn  (presetn),
    .ce       (ce),
    .clr      (!run),
    .tick_in  (t0_adv),
    .div      (t0c_ff.period_prescale_en ? `TTPU_PRESCALE_DIV : 4'h0),
    .tick_out (per_tick)
  );

  // Interrupt point: both counters at zero while the low phase runs
  wire t0_wrap = (main_down_counter_ff == '0) && !phase_hi_ff && (period_cnt_ff == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_down_counter_ff <= `TTPU_RST_VAL;
      period_cnt_ff        <= `TTPU_RST_VAL;
      hi_sh_ff             <= `TTPU_RST_VAL;
      lo_sh_ff             <= `TTPU_RST_VAL;
      phase_hi_ff          <= 1'b0;
      first_timer_irq      <= 1'b0;
    end else if (ce) begin
      first_timer_irq <= 1'b0;
      if (!run) begin
        main_down_counter_ff <= `TTPU_RST_VAL;
        period_cnt_ff        <= `TTPU_RST_VAL;
        hi_sh_ff             <= `TTPU_RST_VAL;
        lo_sh_ff             <= `TTPU_RST_VAL;
        phase_hi_ff          <= 1'b0;
      end else if (t0_adv) begin
        if (t0_wrap) begin
          first_timer_irq      <= 1'b1;
          period_cnt_ff        <= period_reload_ff;
          main_down_counter_ff <= high_phase_reload_ff;
          hi_sh_ff             <= high_phase_reload_ff;
          lo_sh_ff             <= low_phase_reload_ff;
          phase_hi_ff          <= 1'b1;
        end else begin
          if (main_down_counter_ff == '0) begin
            main_down_counter_ff <= phase_hi_ff ? lo_sh_ff : hi_sh_ff;
            phase_hi_ff          <= !phase_hi_ff;
          end else begin
            main_down_counter_ff <= main_down_counter_ff - 16'h0001;
          end
          if (per_tick && period_cnt_ff != '0) begin
            period_cnt_ff <= period_cnt_ff - 16'h0001;
          end
        end
      end
    end
  end

  // PWM pair; clocked mode halves the tick during the high phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_clk_ff        <= 1'b0;
      primary_pulse_out  <= 1'b0;
      inverted_pulse_out <= 1'b1;
    end else if (ce) begin
      if (!run) begin
        half_clk_ff        <= 1'b0;
        primary_pulse_out  <= 1'b0;
        inverted_pulse_out <= 1'b1;
      end else begin
        if (t0_adv) begin
          half_clk_ff <= !half_clk_ff;
        end
        primary_pulse_out  <= phase_hi_ff && (!t0c_ff.clocked_pwm || half_clk_ff);
        inverted_pulse_out <= !(phase_hi_ff && (!t0c_ff.clocked_pwm || half_clk_ff));
      end
    end
  end

  // Second timer: sleep tick replaces the system tick in sleep
  wire t1_tick = sleep_active ? sleep_tick : sys_tick;
  wire t1_adv  = t1c_ff.second_timer_enable && t1_tick;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_timer_count_ff <= `TTPU_RST_VAL;
      second_timer_irq      <= 1'b0;
    end else if (ce) begin
      second_timer_irq <= 1'b0;
      if (!t1c_ff.second_timer_enable) begin
        second_timer_count_ff <= t1c_ff.count_direction_down ? second_timer_reload_ff
                                                             : `TTPU_RST_VAL;
      end else if (t1_adv) begin
        if (t1c_ff.count_direction_down) begin
          if (second_timer_count_ff == '0) begin
            second_timer_irq      <= 1'b1;
            second_timer_count_ff <= second_timer_reload_ff;
          end else begin
            second_timer_count_ff <= second_timer_count_ff - 16'h0001;
          end
        end else if (second_timer_count_ff == second_timer_reload_ff) begin
          second_timer_irq      <= 1'b1;
          second_timer_count_ff <= t1c_ff.free_run ? second_timer_count_ff + 16'h0001
                                                   : `TTPU_RST_VAL;
        end else begin
          second_timer_count_ff <= second_timer_count_ff + 16'h0001;
        end
      end
    end
  end

  // Capture pins cross into pclk before any edge logic sees them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap_s1_ff <= '0;
      cap_s2_ff <= '0;
      cap_d_ff  <= '0;
    end else if (ce) begin
      cap_s1_ff <= capture_pin;
      cap_s2_ff <= cap_s1_ff;
      cap_d_ff  <= cap_s2_ff;
    end
  end

  wire [1:0] pol = {t1c_ff.pol_second, t1c_ff.pol_first};
  wire [1:0] cap_ev = t1c_ff.second_timer_enable ?
                      ((cap_s2_ff ^ cap_d_ff) & (cap_s2_ff ^ pol)) : 2'b00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_first_value_ff  <= `TTPU_RST_VAL;
      capture_second_value_ff <= `TTPU_RST_VAL;
    end else if (ce) begin
      if (cap_ev[0]) begin
        capture_first_value_ff <= second_timer_count_ff;
      end
      if (cap_ev[1]) begin
        capture_second_value_ff <= second_timer_count_ff;
      end
    end
  end

  // One-shot: delay from reload, then width+1 ticks high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shot_st_ff     <= SHOT_IDLE;
      shot_cnt_ff    <= `TTPU_RST_VAL;
      shot_pulse_out <= 1'b0;
    end else if (ce) begin
      case (shot_st_ff)
        SHOT_IDLE: begin
          shot_pulse_out <= 1'b0;
          if (t1c_ff.single_pulse_mode && cap_ev != 2'b00) begin
            shot_st_ff  <= SHOT_DELAY;
            shot_cnt_ff <= second_timer_reload_ff;
          end
        end
        SHOT_DELAY: begin
          if (t1_adv) begin
            if (shot_cnt_ff == '0) begin
              shot_st_ff     <= SHOT_PULSE;
              shot_cnt_ff    <= pulse_width_value_ff;
              shot_pulse_out <= 1'b1;
            end else begin
              shot_cnt_ff <= shot_cnt_ff - 16'h0001;
            end
          end
        end
        SHOT_PULSE: begin
          if (t1_adv) begin
            if (shot_cnt_ff == '0) begin
              shot_st_ff     <= SHOT_IDLE;
              shot_pulse_out <= 1'b0;
            end else begin
              shot_cnt_ff <= shot_cnt_ff - 16'h0001;
            end
          end
        end
        default: begin
          shot_st_ff     <= SHOT_IDLE;
          shot_pulse_out <= 1'b0;
        end
      endcase
    end
  end

  // Sleep PWM runs apart from the counter so sleep keeps the pin alive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spwm_cnt_ff     <= `TTPU_RST_VAL;
      sleep_pulse_out <= 1'b0;
    end else if (ce) begin
      if (t1_adv) begin
        spwm_cnt_ff <= (spwm_cnt_ff >= sleep_pwm_period_ff) ? `TTPU_RST_VAL
                                                            : spwm_cnt_ff + 16'h0001;
      end
      sleep_pulse_out <= t1c_ff.sleep_pin_drive_en && t1c_ff.second_timer_enable &&
                         (spwm_cnt_ff < sleep_pwm_duty_ff);
    end
  end

  // Triple PWM on the 16 MHz tick
  wire t2_en    = t2c_ff.triple_unit_enable;
  wire paused   = t2c_ff.radio_pause_enable && radio_active;
  wire t2_adv   = t2_en && sys_tick && (triple_period_value_ff != '0);
  wire t2_wrap  = t2_adv && (triple_period_counter_ff == '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      triple_period_counter_ff <= '0;
      triple_duty_counter_ff   <= '0;
      tpwm_ff                  <= '0;
      triple_timer_irq         <= 1'b0;
    end else if (ce) begin
      triple_timer_irq <= 1'b0;
      if (!t2_en || triple_period_value_ff == '0) begin
        triple_period_counter_ff <= triple_period_value_ff;
        triple_duty_counter_ff   <= '0;
        tpwm_ff                  <= '0;
      end else if (t2_wrap) begin
        triple_period_counter_ff <= triple_period_value_ff;
        triple_duty_counter_ff   <= '0;
        triple_timer_irq         <= 1'b1;
        for (int i = 0; i < 3; i++) begin
          tpwm_ff[i] <= (start_ff[i] == '0);
        end
      end else if (t2_adv) begin
        triple_period_counter_ff <= triple_period_counter_ff - T2_W'(1);
        if (!paused) begin
          triple_duty_counter_ff <= triple_duty_counter_ff + T2_W'(1);
          for (int i = 0; i < 3; i++) begin
            if (triple_duty_counter_ff == duty_ff[i] ||
                triple_duty_counter_ff == end_ff[i]) begin
              tpwm_ff[i] <= 1'b0;
            end else if (triple_duty_counter_ff == start_ff[i]) begin
              tpwm_ff[i] <= 1'b1;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      triple_pulse_out <= '0;
    end else if (ce) begin
      triple_pulse_out <= paused ? 3'b000 : tpwm_ff;
    end
  end
endmodule

// ===== common/ttpu_map.svh
// Purpose: Offsets, fields, reset values and timing counts of the timer unit
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Byte addresses
`ifndef TTPU_MAP_SVH
`define TTPU_MAP_SVH
`define TTPU_T0_CTRL     12'h000
`define TTPU_T0_HIGH     12'h004
`define TTPU_T0_LOW      12'h008
`define TTPU_T0_PERIOD   12'h00c
`define TTPU_HOLD_SET    12'h010
`define TTPU_HOLD_CLR    12'h014
`define TTPU_T1_CTRL     12'h018
`define TTPU_T1_RELOAD   12'h01c
`define TTPU_T1_COUNT    12'h020
`define TTPU_T1_CAP1     12'h024
`define TTPU_T1_CAP2     12'h028
`define TTPU_T1_WIDTH    12'h02c
`define TTPU_T1_PWM_PER  12'h030
`define TTPU_T1_PWM_DUTY 12'h034
`define TTPU_T2_CTRL     12'h038
`define TTPU_T2_PERIOD   12'h03c
`define TTPU_T2_DUTY0    12'h040
`define TTPU_T2_START0   12'h04c
`define TTPU_T2_END0     12'h058
`define TTPU_T2_LAST     12'h060
// Control field positions
`define TTPU_T0_RUN_BIT    0
`define TTPU_T0_SEL_BIT    1
`define TTPU_T0_PRE_BIT    2
`define TTPU_T0_CLKPWM_BIT 3
`define TTPU_T0_GATE_BIT   4
`define TTPU_T0_DIV_LSB    5
`define TTPU_T1_EN_BIT     0
`define TTPU_T1_DOWN_BIT   1
`define TTPU_T1_SHOT_BIT   2
`define TTPU_T1_FREE_BIT   3
`define TTPU_T1_POL1_BIT   4
`define TTPU_T1_POL2_BIT   5
`define TTPU_T1_PIN_BIT    6
`define TTPU_T2_EN_BIT     0
`define TTPU_T2_PAUSE_BIT  1
// Reset values and counts
`define TTPU_RST_VAL       16'h0000
`define TTPU_PRESCALE_DIV  4'h9
`define TTPU_ERR_RDATA     32'h0000_0000
`endif

// ===== common/ttpu_pkg.sv
// Purpose: Types shared by the timer unit
// Assumes: Offsets and counts live in ttpu_map.svh
// Notes:   None
package ttpu_pkg;
  typedef enum logic [1:0] {SHOT_IDLE, SHOT_DELAY, SHOT_PULSE} ttpu_shot_e;
  typedef struct packed {
    logic [1:0] fast_clock_divider;
    logic       fast_clock_gate;
    logic       clocked_pwm;
    logic       period_prescale_en;
    logic       fast_clock_select;
    logic       first_timer_run;
  } ttpu_t0_ctrl_s;
  typedef struct packed {
    logic sleep_pin_drive_en;
    logic pol_second;
    logic pol_first;
    logic free_run;
    logic single_pulse_mode;
    logic count_direction_down;
    logic second_timer_enable;
  } ttpu_t1_ctrl_s;
  typedef struct packed {
    logic radio_pause_enable;
    logic triple_unit_enable;
  } ttpu_t2_ctrl_s;
endpackage

// ===== rtl/ttpu_tick_div.sv
// Purpose: Divides a tick enable by div+1
// Assumes: Ticks are one-cycle pulses on pclk
// Notes:   A divide value of zero passes every tick
module ttpu_tick_div
  import ttpu_pkg::*;
#(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Tick path
  input  wire logic         clr,
  input  wire logic         tick_in,
  input  wire logic [W-1:0] div,
  output logic              tick_out
);
  logic [W-1:0] cnt_ff;

  if (W < 1) begin : g_chk
    $error("ttpu_tick_div: W must be at least 1");
  end

  assign tick_out = tick_in && (cnt_ff >= div);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (ce) begin
      if (clr || tick_out) begin
        cnt_ff <= '0;
      end else if (tick_in) begin
        cnt_ff <= cnt_ff + W'(1);
      end
    end
  end
endmodule

// ===== tb/ttpu_top_asserts.sv
// Purpose: Port-level checks of the timer unit
// Assumes: Control bits are tracked from completed APB writes
// Notes:   Port subset only; bound from the test top
`include "ttpu_map.svh"
module ttpu_top_asserts (
  // Clock and APB
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic        radio_active,
  input wire logic        primary_pulse_out,
  input wire logic        inverted_pulse_out,
  input wire logic        sleep_pulse_out,
  input wire logic [2:0]  triple_pulse_out,
  input wire logic        first_timer_irq,
  input wire logic        second_timer_irq,
  input wire logic        triple_timer_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic run_ff, hold_ff, pause_ff, pin_ff;
  wire logic [2:0] irqs = {first_timer_irq, second_timer_irq, triple_timer_irq};
  // Mirrors only the bits the properties need
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {run_ff, hold_ff, pause_ff, pin_ff} <= 4'h0;
    end else if (psel && penable && pwrite) begin
      if (paddr == `TTPU_T0_CTRL) run_ff <= pwdata[0];
      if (paddr == `TTPU_HOLD_SET && pwdata[0]) hold_ff <= 1'b1;
      if (paddr == `TTPU_HOLD_CLR && pwdata[0]) hold_ff <= 1'b0;
      if (paddr == `TTPU_T2_CTRL) pause_ff <= pwdata[1];
      if (paddr == `TTPU_T1_CTRL) pin_ff <= pwdata[6];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_inverse_pair: assert property (inverted_pulse_out == !primary_pulse_out)
    else $error("inverted output not inverse");
  a_irq_single: assert property ((irqs & $past(irqs)) == 3'h0)
    else $error("interrupt longer than one cycle");
  a_idle_quiet: assert property (!run_ff ##1 !run_ff |-> !primary_pulse_out && !first_timer_irq)
    else $error("stopped timer active");
  a_hold_still: assert property (hold_ff ##1 hold_ff ##1 hold_ff |-> $stable(primary_pulse_out) && !first_timer_irq)
    else $error("held timer moved");
  a_pause_low: assert property (pause_ff && radio_active ##1 radio_active |-> triple_pulse_out == 3'h0)
    else $error("triple outputs high during radio");
  a_sleep_gated: assert property (!pin_ff ##1 !pin_ff |-> !sleep_pulse_out)
    else $error("sleep output without pin drive");
  a_unmapped_err: assert property (psel && !penable && (paddr > `TTPU_T2_LAST || paddr[1:0] != 2'b00) |=> pslverr)
    else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && !penable && paddr <= `TTPU_T2_LAST && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped access with error");
  a_ready_set: assert property (pready)
    else $error("wait state seen");
  cover property (first_timer_irq);
  cover property (hold_ff && primary_pulse_out);
  cover property (pause_ff && radio_active);
endmodule

// ===== tb/triple_timer_pwm_unit_test.sv
// Purpose: Random and corner stimulus for the timer unit
// Assumes: Zero period value, so every low phase end is a wrap
// Notes:   step() models main counter phases with a low shadow
`include "ttpu_map.svh"
module triple_timer_pwm_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sys_tick = 0, slow_tick = 0;
  logic radio_active = 0, pready, pslverr, primary_pulse_out, inverted_pulse_out, first_timer_irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [2:0]  trip;
  logic        err, shot, irq1, irq2;
  logic [1:0]  cap = 0;
  int fails, checks, nirq, eirq, h, l, sl, m, ph, started, r, n1, n2;
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (first_timer_irq === 1'b1) nirq++;
  always @(posedge pclk) if (irq1 === 1'b1) n1++;
  always @(posedge pclk) if (irq2 === 1'b1) n2++;
  ttpu_top uut (.pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .sys_tick, .slow_tick, .sleep_tick(1'b0), .sleep_active(1'b0),
    .radio_active, .capture_pin(cap), .primary_pulse_out, .inverted_pulse_out,
    .shot_pulse_out(shot), .sleep_pulse_out(), .triple_pulse_out(trip), .first_timer_irq,
    .second_timer_irq(irq1), .triple_timer_irq(irq2));
  task end_of_test();
    if (fails == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr; psel <= 0; penable <= 0;
  endtask
  // The unselected source pulses first and must be ignored
  task tk(input int f);
    @(posedge pclk); {sys_tick, slow_tick} <= f ? 2'b01 : 2'b10;
    @(posedge pclk); {sys_tick, slow_tick} <= f ? 2'b10 : 2'b01;
    @(posedge pclk); {sys_tick, slow_tick} <= 2'b00;
    repeat (3) @(posedge pclk);
  endtask
  function void step();
    if (!started) begin started = 1; eirq++; m = h; sl = l; ph = 1; end
    else if (m != 0) m--;
    else if (ph) begin ph = 0; m = sl; end
    else begin eirq++; m = h; sl = l; ph = 1; end
  endfunction
  initial begin #50us; fails++; end_of_test(); end
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    void'($urandom(9));
    for (int a = 4; a <= 12; a += 4) begin apb(0, a, 0); chk("reset read", rd, 0); end
    apb(0, 12'h100, 0); chk("unmapped err", err, 1); chk("unmapped data", rd, 0);
    for (int f = 0; f < 2; f++) begin
      h = $urandom % 4; l = $urandom % 4; started = 0; eirq = nirq;
      apb(1, `TTPU_T0_HIGH, h); apb(1, `TTPU_T0_LOW, l); apb(1, `TTPU_T0_PERIOD, 0);
      apb(1, `TTPU_T0_CTRL, f ? 32'h13 : 32'h1);
      for (int i = 0; i < 30; i++) begin
        if (i == 7) begin
          h = $urandom % 4; l = $urandom % 4; apb(1, `TTPU_T0_HIGH, h); apb(1, `TTPU_T0_LOW, l);
        end
        if (i == 20) apb(1, `TTPU_HOLD_SET, 1);
        if (i == 22) apb(1, `TTPU_HOLD_CLR, 1);
        tk(f);
        if (i < 20 || i > 21) step();
        chk("primary", primary_pulse_out, ph);
        chk("irq count", nirq, eirq);
      end
      apb(0, `TTPU_T0_LOW, 0); chk("main count", rd, m);
      apb(1, `TTPU_T0_CTRL, 0); repeat (2) @(posedge pclk);
      chk("stopped out", {primary_pulse_out, inverted_pulse_out}, 2'b01);
    end
    r = 1 + $urandom % 4; apb(1, `TTPU_T1_RELOAD, r); apb(1, `TTPU_T1_WIDTH, 1);
    apb(1, `TTPU_T1_CTRL, 5);
    for (int i = 1; i <= 12; i++) begin
      tk(1);
      chk("shot", shot, i >= 6 + r && i < 8 + r);
      if (i == 5 || i == 11) begin
        cap <= (i == 5) ? 2'b01 : 2'b11;
        repeat (4) @(posedge pclk);
      end
    end
    chk("second irqs", n1, 12 / (r + 1));
    apb(0, `TTPU_T1_COUNT, 0); chk("second count", rd, 12 % (r + 1));
    apb(0, `TTPU_T1_CAP1, 0); chk("capture 1", rd, 5 % (r + 1));
    apb(0, `TTPU_T1_CAP2, 0); chk("capture 2", rd, 11 % (r + 1));
    apb(1, `TTPU_T1_CTRL, 0);
    apb(1, `TTPU_T2_PERIOD, 5); apb(1, `TTPU_T2_DUTY0, 3);
    apb(1, `TTPU_T2_END0, 4); apb(1, `TTPU_T2_CTRL, 3);
    for (int k = 1; k <= 8; k++) begin
      tk(1);
      chk("triple", trip, {{2{k % 6 == 0}}, k % 6 <= 3});
    end
    chk("triple irqs", n2, 1);
    radio_active <= 1;
    repeat (3) tk(1);
    chk("triple", trip, 0);
    radio_active <= 0;
    end_of_test();
  end
endmodule
bind ttpu_top ttpu_top_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pready, .pslverr, .radio_active, .primary_pulse_out, .inverted_pulse_out, .sleep_pulse_out,
  .triple_pulse_out, .first_timer_irq, .second_timer_irq, .triple_timer_irq);
